// ==== lfb_port_consts.svh ====
`ifndef LFB_PORT_CONSTS_SVH
`define LFB_PORT_CONSTS_SVH

// Register byte addresses
`define AXI_ADDR_W 8
`define REG_PIXEL_PORT_CONFIG 8'h00
`define REG_RENDER_MODE_CONFIG 8'h04
`define REG_CONSTANT_DEPTH_ALPHA 8'h08
`define REG_MEMORY_BASE_BAR 8'h0C
`define REG_SCREEN_SIZE 8'h10
`define REG_STATUS 8'h14
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2
`define RST_WORD 32'h0000_0000

// Pixel window
`define LFB_WINDOW_OFFSET 32'h0080_0000
`define LFB_WINDOW_BITS 22

// Field positions
`define CFG_FMT_MSB 3
`define CFG_FMT_LSB 0
`define CFG_HALF_SWAP_BIT 11
`define CFG_ORDER_MSB 12
`define CFG_ORDER_LSB 9
`define ORD_BGR_BIT 0
`define ORD_ALPHA_LAST_BIT 1
`define RMODE_SCISSOR_BIT 0
`define RMODE_Y_FLIP_BIT 16
`define ZA_DEPTH_MSB 15
`define ZA_DEPTH_LSB 0
`define ZA_ALPHA_MSB 31
`define ZA_ALPHA_LSB 24
`define SCR_W_MSB 9
`define SCR_W_LSB 0
`define SCR_H_MSB 25
`define SCR_H_LSB 16
`define STAT_BUSY_BIT 31
`define STAT_WAIT_BIT 30
`define STAT_DISCARD_MSB 7

// Offset to position, 2048 and 4096 pitch
`define P16_X_MSB 10
`define P16_X_LSB 2
`define P16_Y_MSB 20
`define P16_Y_LSB 11
`define P32_X_MSB 11
`define P32_X_LSB 2
`define P32_Y_MSB 21
`define P32_Y_LSB 12

// Write format codes
`define FMT_565 4'h0
`define FMT_X555 4'h1
`define FMT_1555 4'h2
`define FMT_RSVD3 4'h3
`define FMT_888 4'h4
`define FMT_8888 4'h5
`define FMT_RSVD_LO 4'h6
`define FMT_RSVD_HI 4'hB
`define FMT_Z565 4'hC
`define FMT_ZX555 4'hD
`define FMT_Z1555 4'hE
`define FMT_ZZ 4'hF

`endif

// ==== lfb_port_pkg.sv ====
package lfb_port_pkg;

  typedef struct packed {
    logic write;
    logic [9:0] x;
    logic [9:0] y;
    logic [31:0] color;
    logic [15:0] depth;
    logic color_we;
    logic depth_we;
  } fb_req_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_WR = 6'h02,
    ST_RWAIT = 6'h04,
    ST_RD = 6'h08,
    ST_RDATA = 6'h10,
    ST_DONE = 6'h20
  } lfb_state_t;

endpackage : lfb_port_pkg

// ==== pixel_unpack.sv ====
`timescale 1ns/1ps
`include "lfb_port_consts.svh"

module pixel_unpack (
  // Format selection
  input wire logic [3:0] fmt,
  input wire logic [3:0] order,
  input wire logic half_swap,
  input wire logic idx,
  // Host word and constants
  input wire logic [31:0] word,
  input wire logic [31:0] za,
  // Unpacked pixel
  output logic [31:0] color,
  output logic [15:0] depth,
  output logic color_we
);

  wire [15:0] left_h = half_swap ? word[31:16] : word[15:0];
  wire [15:0] right_h = half_swap ? word[15:0] : word[31:16];
  wire [15:0] pix_h = idx ? right_h : left_h;
  wire is_z16 = (fmt >= `FMT_Z565) && (fmt <= `FMT_Z1555);
  wire is_zz = (fmt == `FMT_ZZ);
  wire is_565 = (fmt == `FMT_565) || (fmt == `FMT_Z565);
  wire is_32 = (fmt == `FMT_888) || (fmt == `FMT_8888);
  // Alpha from data for formats 3, 5 and 14; constant for the rest, 1555 included
  wire a_from_data = (fmt == `FMT_RSVD3) || (fmt == `FMT_8888) || (fmt == `FMT_Z1555); // see RL9 see RL13 see RL14
  wire [15:0] col_h = is_z16 ? left_h : pix_h; // see RL15
  wire [15:0] dep_h = is_z16 ? right_h : pix_h; // see RL15
  wire alpha_last = order[`ORD_ALPHA_LAST_BIT];
  wire bgr = order[`ORD_BGR_BIT];
  wire [15:0] n16 = (alpha_last && !is_565) ? {col_h[0], col_h[15:1]} : col_h; // see RL10
  wire [31:0] n32 = alpha_last ? {word[7:0], word[31:8]} : word; // see RL10
  wire [4:0] r5 = is_565 ? n16[15:11] : n16[14:10];
  wire [7:0] g16 = is_565 ? {n16[10:5], n16[10:9]} : {n16[9:5], n16[9:7]};
  wire [4:0] b5 = n16[4:0];
  wire [7:0] r8 = is_32 ? n32[23:16] : {r5, r5[4:2]};
  wire [7:0] g8 = is_32 ? n32[15:8] : g16;
  wire [7:0] b8 = is_32 ? n32[7:0] : {b5, b5[4:2]};
  wire [7:0] a_data = is_32 ? n32[31:24] : {8{n16[15]}};
  wire [7:0] a8 = a_from_data ? a_data : za[`ZA_ALPHA_MSB:`ZA_ALPHA_LSB];

  assign color = bgr ? {a8, b8, g8, r8} : {a8, r8, g8, b8}; // see RL10
  // Depth from data where carried
  assign depth = (is_z16 || is_zz) ? dep_h : za[`ZA_DEPTH_MSB:`ZA_DEPTH_LSB]; // see RL8 see RL13 see RL14
  assign color_we = !is_zz;

endmodule : pixel_unpack

// ==== linear_frame_buffer_port.sv ====
// Function
// RL1 - 4 MB pixel window starts 8 MB above the base register.
// RL2 - Positions assume a 1024-pixel logical line.
// RL3 - Offset 0 is top-left, or bottom-left with render mode bit 16.
// RL4 - Rising addresses walk left to right.
// RL5 - Clip writes only with scissor bit 0; else host stays on screen.
// RL6 - Four-bit field selects the write format; some codes reserved.
// RL7 - 16-bit formats: 2048 pitch, two pixels a word, order by bit 11.
// RL8 - Formats 0 to 3 take depth from the constant register.
// RL9 - Alpha from data for format 3, from constant for 0 to 2.
// RL10 - Channel order follows configuration bits 12 to 9.
// RL11 - Formats 4, 5: 4096 pitch, one pixel a word.
// RL12 - Host puts each 24-bit pixel in its own aligned word.
// RL13 - Formats 4, 5 take constant depth; alpha constant for 4, data for 5.
// RL14 - Formats 12 to 14: 4096 pitch, one pixel, missing depth/alpha constant.
// RL15 - Formats 12 to 15 place halves by bit 11.
// RL16 - Reads: two 16-bit pixels a word, 2048 pitch, order by bit 11.
// RL17 - Reads wait for empty FIFO and flushed pipeline.
// RL18 - Host should check idle status before reading.
// RL19 - Host uses 32-bit or 16-bit window accesses, never bytes.
// RL20 - Reserved format writes are dropped untouched.
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "lfb_port_consts.svh"

module linear_frame_buffer_port #(
  parameter logic [9:0] SCREEN_W = 10'h280,
  parameter logic [9:0] SCREEN_H = 10'h1E0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // AXI4-Lite register slave
  input wire logic [`AXI_ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [`AXI_ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Host memory access
  input wire logic host_req,
  input wire logic host_write,
  input wire logic [31:0] host_addr,
  input wire logic [31:0] host_wdata,
  input wire logic [3:0] host_be,
  output logic host_ack,
  output logic [31:0] host_rdata,
  // Engine state
  input wire logic cmd_fifo_empty,
  input wire logic pixel_pipe_idle,
  // Frame buffer path
  output lfb_port_pkg::fb_req_t fb_req,
  output logic fb_valid,
  input wire logic fb_ready,
  input wire logic fb_rvalid,
  input wire logic [15:0] fb_rdata
);

  // Registers
  logic [31:0] pixel_port_config_q, render_mode_config_q, constant_depth_alpha_q;
  logic [31:0] memory_base_bar_q, screen_size_q;
  logic [`STAT_DISCARD_MSB:0] discard_cnt_q;
  // Bus slave state
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [`AXI_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  // Access engine state
  lfb_port_pkg::lfb_state_t state_q;
  logic idx_q, ack_q, fbv_q;
  logic [31:0] off_q, word_q, hrdata_q;
  logic [3:0] be_q;
  logic [15:0] rd_pix_q [2];
  lfb_port_pkg::fb_req_t fbreq_q;
  // Unwritten byte lanes keep their bits
  wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  function automatic logic [31:0] merge(input logic [31:0] old);
    return (old & ~wmask) | (wdata_q & wmask);
  endfunction : merge
  // Field decode
  wire [3:0] fmt = pixel_port_config_q[`CFG_FMT_MSB:`CFG_FMT_LSB]; // see RL6
  wire [3:0] order = pixel_port_config_q[`CFG_ORDER_MSB:`CFG_ORDER_LSB];
  wire half_swap = pixel_port_config_q[`CFG_HALF_SWAP_BIT];
  wire scissor_on = render_mode_config_q[`RMODE_SCISSOR_BIT];
  wire y_flip = render_mode_config_q[`RMODE_Y_FLIP_BIT];
  wire [9:0] scr_w = screen_size_q[`SCR_W_MSB:`SCR_W_LSB];
  wire [9:0] scr_h = screen_size_q[`SCR_H_MSB:`SCR_H_LSB];

  // Window decode
  wire [31:0] host_off = host_addr - memory_base_bar_q - `LFB_WINDOW_OFFSET; // see RL1
  wire win_hit = (host_off[31:`LFB_WINDOW_BITS] == '0); // see RL1
  wire fmt_rsvd = (fmt == `FMT_RSVD3) || ((fmt >= `FMT_RSVD_LO) && (fmt <= `FMT_RSVD_HI)); // see RL6
  wire two_pix = (fmt <= `FMT_RSVD3) || (fmt == `FMT_ZZ); // see RL7

  // Pixel position, one 1024-pixel logical line per pitch
  wire [9:0] x16 = {off_q[`P16_X_MSB:`P16_X_LSB], idx_q}; // see RL2 see RL4 see RL7
  wire [9:0] y16 = off_q[`P16_Y_MSB:`P16_Y_LSB]; // see RL2 see RL16
  wire [9:0] x32 = off_q[`P32_X_MSB:`P32_X_LSB]; // see RL11 see RL14
  wire [9:0] y32 = off_q[`P32_Y_MSB:`P32_Y_LSB]; // see RL11 see RL14
  wire use16 = two_pix || (state_q != lfb_port_pkg::ST_WR); // see RL16
  wire [9:0] x_raw = use16 ? x16 : x32;
  wire [9:0] y_raw = use16 ? y16 : y32;
  // With Y flip, rows past the height wrap; scissor catches those
  wire [9:0] y_scr = y_flip ? (scr_h - 10'h001 - y_raw) : y_raw; // see RL3
  wire clipped = scissor_on && ((x_raw >= scr_w) || (y_raw >= scr_h)); // see RL5
  wire half_en = two_pix ? ((idx_q ^ half_swap) ? |be_q[3:2] : |be_q[1:0]) : 1'b1; // see RL7
  wire pix_need = half_en && !clipped;
  wire last_idx = two_pix ? 1'b1 : 1'b0; // see RL11

  // Unpacked write pixel
  logic [31:0] up_color;
  logic [15:0] up_depth;
  logic up_color_we;

  pixel_unpack u_unpack (
    .fmt(fmt),
    .order(order),
    .half_swap(half_swap),
    .idx(idx_q),
    .word(word_q),
    .za(constant_depth_alpha_q),
    .color(up_color),
    .depth(up_depth),
    .color_we(up_color_we)
  );

  lfb_port_pkg::fb_req_t wr_pix, rd_pix;
  assign wr_pix = '{write: 1'b1, x: x_raw, y: y_scr, color: up_color, depth: up_depth,
                    color_we: up_color_we, depth_we: 1'b1};
  assign rd_pix = '{write: 1'b0, x: x16, y: y_scr, color: '0, depth: '0,
                    color_we: 1'b0, depth_we: 1'b0};

  // Blue-first order swaps red and blue on reads
  wire bgr = order[`ORD_BGR_BIT];
  wire [15:0] rd0 = bgr ? {rd_pix_q[0][4:0], rd_pix_q[0][10:5], rd_pix_q[0][15:11]}
                        : rd_pix_q[0]; // see RL10
  wire [15:0] rd1 = bgr ? {rd_pix_q[1][4:0], rd_pix_q[1][10:5], rd_pix_q[1][15:11]}
                        : rd_pix_q[1];
  wire [31:0] rd_word = half_swap ? {rd0, rd1} : {rd1, rd0}; // see RL16

  // Access engine
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= lfb_port_pkg::ST_IDLE;
      idx_q <= 1'b0;
      off_q <= `RST_WORD;
      word_q <= `RST_WORD;
      be_q <= 4'h0;
      rd_pix_q <= '{default: 16'h0000};
      ack_q <= 1'b0;
      hrdata_q <= `RST_WORD;
      fbv_q <= 1'b0;
      fbreq_q <= '0;
      discard_cnt_q <= '0;
    end else begin
      ack_q <= 1'b0;
      case (state_q)
        lfb_port_pkg::ST_IDLE: begin
          // Ack high: host has not yet dropped this request
          if (host_req && !ack_q) begin
            off_q <= host_off;
            word_q <= host_wdata;
            be_q <= host_be;
            idx_q <= 1'b0;
            hrdata_q <= `RST_WORD;
            if (!win_hit) state_q <= lfb_port_pkg::ST_DONE;
            else if (host_write && fmt_rsvd) begin
              discard_cnt_q <= discard_cnt_q + 1'b1; // see RL20
              state_q <= lfb_port_pkg::ST_DONE;
            end else if (host_write) state_q <= lfb_port_pkg::ST_WR;
            else state_q <= lfb_port_pkg::ST_RWAIT;
          end
        end
        lfb_port_pkg::ST_WR: begin
          if (!fbv_q && pix_need) begin
            fbv_q <= 1'b1;
            fbreq_q <= wr_pix;
          end else if (!fbv_q || fb_ready) begin
            fbv_q <= 1'b0;
            if (idx_q == last_idx) state_q <= lfb_port_pkg::ST_DONE;
            else idx_q <= 1'b1;
          end
        end
        lfb_port_pkg::ST_RWAIT: begin
          // Blocking read: memory is touched only once queued work drains
          if (cmd_fifo_empty && pixel_pipe_idle) state_q <= lfb_port_pkg::ST_RD; // see RL17
        end
        lfb_port_pkg::ST_RD: begin
          if (!fbv_q) begin
            fbv_q <= 1'b1;
            fbreq_q <= rd_pix;
          end else if (fb_ready) begin
            fbv_q <= 1'b0;
            state_q <= lfb_port_pkg::ST_RDATA;
          end
        end
        lfb_port_pkg::ST_RDATA: begin
          if (fb_rvalid) begin
            rd_pix_q[idx_q] <= fb_rdata;
            if (idx_q) begin
              state_q <= lfb_port_pkg::ST_DONE;
            end else begin
              idx_q <= 1'b1;
              state_q <= lfb_port_pkg::ST_RD;
            end
          end
        end
        lfb_port_pkg::ST_DONE: begin
          ack_q <= 1'b1;
          if (idx_q && !fbreq_q.write && fbreq_q.x[0]) hrdata_q <= rd_word; // see RL16
          state_q <= lfb_port_pkg::ST_IDLE;
        end
        default: state_q <= lfb_port_pkg::ST_IDLE;
      endcase
    end
  end

  // Register write channel
  wire wr_fire = !awready_q && !wready_q && !bvalid_q;
  wire wr_hit = (awaddr_q == `REG_PIXEL_PORT_CONFIG) || (awaddr_q == `REG_RENDER_MODE_CONFIG)
             || (awaddr_q == `REG_CONSTANT_DEPTH_ALPHA) || (awaddr_q == `REG_MEMORY_BASE_BAR)
             || (awaddr_q == `REG_SCREEN_SIZE);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `AXI_RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= `RST_WORD;
      wstrb_q <= 4'h0;
    end else begin
      if (s_awvalid && awready_q) begin
        awaddr_q <= s_awaddr;
        awready_q <= 1'b0;
      end
      if (s_wvalid && wready_q) begin
        wdata_q <= s_wdata;
        wstrb_q <= s_wstrb;
        wready_q <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
      if (bvalid_q && s_bready) bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pixel_port_config_q <= `RST_WORD;
      render_mode_config_q <= `RST_WORD;
      constant_depth_alpha_q <= `RST_WORD;
      memory_base_bar_q <= `RST_WORD;
      screen_size_q <= {6'h00, SCREEN_H, 6'h00, SCREEN_W};
    end else if (wr_fire) begin
      case (awaddr_q)
        `REG_PIXEL_PORT_CONFIG: pixel_port_config_q <= merge(pixel_port_config_q);
        `REG_RENDER_MODE_CONFIG: render_mode_config_q <= merge(render_mode_config_q);
        `REG_CONSTANT_DEPTH_ALPHA: constant_depth_alpha_q <= merge(constant_depth_alpha_q);
        `REG_MEMORY_BASE_BAR: memory_base_bar_q <= merge(memory_base_bar_q);
        `REG_SCREEN_SIZE: screen_size_q <= merge(screen_size_q);
        default: ;
      endcase
    end
  end

  // Register read channel
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    rd_mux = `RST_WORD;
    case (s_araddr)
      `REG_PIXEL_PORT_CONFIG: rd_mux = pixel_port_config_q;
      `REG_RENDER_MODE_CONFIG: rd_mux = render_mode_config_q;
      `REG_CONSTANT_DEPTH_ALPHA: rd_mux = constant_depth_alpha_q;
      `REG_MEMORY_BASE_BAR: rd_mux = memory_base_bar_q;
      `REG_SCREEN_SIZE: rd_mux = screen_size_q;
      `REG_STATUS: begin
        rd_mux[`STAT_BUSY_BIT] = (state_q != lfb_port_pkg::ST_IDLE);
        rd_mux[`STAT_WAIT_BIT] = (state_q == lfb_port_pkg::ST_RWAIT);
        rd_mux[`STAT_DISCARD_MSB:0] = discard_cnt_q;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= `AXI_RESP_OKAY;
      rdata_q <= `RST_WORD;
    end else if (s_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end else if (rvalid_q && s_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // Outputs
  assign s_awready = awready_q;
  assign s_wready = wready_q;
  assign s_bvalid = bvalid_q;
  assign s_bresp = bresp_q;
  assign s_arready = arready_q;
  assign s_rvalid = rvalid_q;
  assign s_rresp = rresp_q;
  assign s_rdata = rdata_q;
  assign host_ack = ack_q;
  assign host_rdata = hrdata_q;
  assign fb_valid = fbv_q;
  assign fb_req = fbreq_q;

endmodule : linear_frame_buffer_port

// ==== lfb_port_chk.sv ====
`timescale 1ns/1ps
module lfb_port_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register bus
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic [1:0] s_bresp,
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic s_rvalid,
  input wire logic s_rready,
  // Host and engine
  input wire logic host_req,
  input wire logic host_write,
  input wire logic host_ack,
  input wire logic cmd_fifo_empty,
  input wire logic pixel_pipe_idle,
  // Frame buffer path
  input wire lfb_port_pkg::fb_req_t fb_req,
  input wire logic fb_valid,
  input wire logic fb_ready
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic gate_q;
  logic [9:0] rdx_q;
  // Idle seen while a read is pending; its ack clears it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gate_q <= 1'b0;
      rdx_q <= 10'h000;
    end else begin
      gate_q <= !host_ack && (gate_q || (host_req && !host_write && cmd_fifo_empty
                                         && pixel_pipe_idle));
      if (fb_valid && fb_ready && !fb_req.write) begin
        rdx_q <= fb_req.x;
      end
    end
  end
  a_read_gate: assert property (fb_valid && !fb_req.write |-> gate_q)
    else $error("read before drain");
  a_read_pair: assert property (fb_valid && !fb_req.write && fb_req.x[0] |->
    rdx_q == {fb_req.x[9:1], 1'b0}) else $error("odd read unpaired");
  a_fb_hold: assert property (fb_valid && !fb_ready |=> fb_valid && $stable(fb_req))
    else $error("fb request moved");
  a_fb_in_req: assert property (fb_valid |-> host_req)
    else $error("fb access unasked");
  a_ack_pulse: assert property (host_ack |=> !host_ack)
    else $error("ack too long");
  a_wr_kind: assert property (fb_valid && fb_req.write |-> host_write && fb_req.depth_we)
    else $error("stray fb write");
  a_wr_resp: assert property (s_awvalid && s_awready && s_wvalid && s_wready |->
    ##[1:2] s_bvalid) else $error("late bresp");
  a_b_hold: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("bresp dropped");
  a_rd_resp: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("late rresp");
  a_r_hold: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("rdata moved");
endmodule : lfb_port_chk

bind linear_frame_buffer_port lfb_port_chk i_chk (
  .clk_sys, .rst, .s_awvalid, .s_awready, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
  .s_arvalid, .s_arready, .s_rdata, .s_rvalid, .s_rready, .host_req, .host_write, .host_ack,
  .cmd_fifo_empty, .pixel_pipe_idle, .fb_req, .fb_valid, .fb_ready
);

// ==== fb_mem_model.sv ====
`timescale 1ns/1ps
module fb_mem_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Frame buffer path
  input wire lfb_port_pkg::fb_req_t fb_req,
  input wire logic fb_valid,
  output logic fb_ready,
  output logic fb_rvalid,
  output logic [15:0] fb_rdata,
  // Pacing, stall every other cycle
  input wire logic slow
);
  logic [15:0] col_m [int];
  logic [15:0] dep_m [int];
  int wr_cnt = 0;
  int rd_cnt = 0;
  int k;
  // Stored as 5-6-5
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fb_ready <= 1'b0;
      fb_rvalid <= 1'b0;
      fb_rdata <= 16'hA5A5;
    end else begin
      fb_ready <= slow ? !fb_ready : 1'b1;
      fb_rvalid <= 1'b0;
      k = {fb_req.y, fb_req.x};
      if (fb_valid && fb_ready && fb_req.write) begin
        wr_cnt++;
        if (fb_req.color_we) col_m[k] = {fb_req.color[23:19], fb_req.color[15:10],
                                         fb_req.color[7:3]};
        if (fb_req.depth_we) dep_m[k] = fb_req.depth;
      end
      if (fb_valid && fb_ready && !fb_req.write) begin
        rd_cnt++;
        fb_rvalid <= 1'b1;
        fb_rdata <= col_m.exists(k) ? col_m[k] : 16'h0000;
      end else begin
        // Toggles so stale data never looks valid
        fb_rdata <= ~fb_rdata;
      end
    end
  end
endmodule : fb_mem_model

// ==== tb_top.sv ====
`timescale 1ns/1ps
`include "lfb_port_consts.svh"
module tb_top;
  localparam int SCR_H = 480;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0000_0000, host_addr = 32'h0000_0000, host_wdata = 32'h0000_0000;
  logic [3:0] s_wstrb = 4'hF, host_be = 4'hF;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic host_req = 1'b0, host_write = 1'b0, cmd_fifo_empty = 1'b1, pixel_pipe_idle = 1'b1;
  logic slow = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, host_ack, fb_valid, fb_ready, fb_rvalid;
  logic [1:0] s_bresp, s_rresp;
  logic [31:0] s_rdata, host_rdata;
  logic [15:0] fb_rdata;
  lfb_port_pkg::fb_req_t fb_req;
  logic [31:0] bar = 32'h1000_0000;
  int error_cnt = 0;
  int n_compared = 0;

  initial begin
    forever #2 clk_sys = ~clk_sys;
  end

  linear_frame_buffer_port i_linear_frame_buffer_port (
    .clk_sys, .rst, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
    .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
    .s_rvalid, .s_rready, .host_req, .host_write, .host_addr, .host_wdata, .host_be, .host_ack,
    .host_rdata, .cmd_fifo_empty, .pixel_pipe_idle, .fb_req, .fb_valid, .fb_ready, .fb_rvalid,
    .fb_rdata
  );
  fb_mem_model i_fb_mem_model (
    .clk_sys, .rst, .fb_req, .fb_valid, .fb_ready, .fb_rvalid, .fb_rdata, .slow
  );

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tmo(input int n);
    if (n >= 200) begin
      error_cnt++;
      $display("MISMATCH wait expected ack seen none");
      report_and_stop();
    end
  endtask : tmo

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk_sys);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    for (n = 0; n < 200 && !s_bvalid; n++) begin
      @(posedge clk_sys);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end
    tmo(n);
    chk("bresp", 32'(s_bresp), 32'(er));
    s_bready <= 1'b0;
  endtask : axi_wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    @(posedge clk_sys);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    for (n = 0; n < 200 && !s_rvalid; n++) begin
      @(posedge clk_sys);
      if (s_arready) s_arvalid <= 1'b0;
    end
    tmo(n);
    chk("rdata", s_rdata, e);
    chk("rresp", 32'(s_rresp), 32'(er));
    s_rready <= 1'b0;
  endtask : rchk

  task automatic cfg(input logic [31:0] d);
    axi_wr(`REG_PIXEL_PORT_CONFIG, d, `AXI_RESP_OKAY);
  endtask : cfg

  task automatic hst(input logic w, input logic [31:0] off, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    host_req <= 1'b1;
    host_write <= w;
    host_addr <= bar + `LFB_WINDOW_OFFSET + off;
    host_wdata <= d;
    for (n = 0; n < 200 && host_ack !== 1'b1; n++) @(posedge clk_sys);
    tmo(n);
    q = host_rdata;
    host_req <= 1'b0;
  endtask : hst

  task automatic wr(input logic [31:0] off, input logic [31:0] d);
    logic [31:0] q;
    hst(1'b1, off, d, q);
  endtask : wr

  task automatic px(input int x, input int y, input logic [15:0] e, input bit dep);
    int k = y * 1024 + x;
    if (dep) chk("depth", 32'(i_fb_mem_model.dep_m[k]), 32'(e));
    else chk("colour", 32'(i_fb_mem_model.col_m[k]), 32'(e));
  endtask : px

  task automatic t_regs();
    for (int a = 0; a < 16; a += 4) rchk(8'(a), `RST_WORD, `AXI_RESP_OKAY);
    rchk(`REG_SCREEN_SIZE, 32'h01E0_0280, `AXI_RESP_OKAY);
    rchk(8'h18, 32'h0000_0000, `AXI_RESP_SLVERR);
    axi_wr(`REG_STATUS, 32'hFFFF_FFFF, `AXI_RESP_SLVERR);
    rchk(`REG_STATUS, 32'h0000_0000, `AXI_RESP_OKAY);
    axi_wr(`REG_CONSTANT_DEPTH_ALPHA, 32'hA500_1234, `AXI_RESP_OKAY);
    rchk(`REG_CONSTANT_DEPTH_ALPHA, 32'hA500_1234, `AXI_RESP_OKAY);
    axi_wr(`REG_MEMORY_BASE_BAR, bar, `AXI_RESP_OKAY);
    $display("test regs done");
  endtask : t_regs

  task automatic t_p16();
    cfg(32'h0000_0000);
    wr(32'h0000_1814, 32'hF800_001F);
    px(10, 3, 16'h001F, 0);
    px(11, 3, 16'hF800, 0);
    px(11, 3, 16'h1234, 1);
    cfg(32'h0000_0800);
    wr(32'h0000_2014, 32'hF800_001F);
    px(10, 4, 16'hF800, 0);
    cfg(32'h0000_0200);
    wr(32'h0000_2818, 32'h001F_F800);
    px(12, 5, 16'h001F, 0);
    cfg(32'h0000_080F);
    wr(32'h0000_3028, 32'hBBBB_AAAA);
    px(20, 6, 16'hBBBB, 1);
    px(21, 6, 16'hAAAA, 1);
    $display("p16 done");
  endtask : t_p16

  task automatic t_p32();
    int n;
    logic [11:0] c [6] = '{12'h005, 12'h004, 12'h00C, 12'h00D, 12'h00E, 12'h80C};
    logic [31:0] d [6] = '{32'h80FF_0000, 32'h0000_00FF, 32'h4321_F800, 32'h5555_7C00,
                           32'h6666_FC00, 32'hF800_4321};
    logic [15:0] ed [6] = '{16'h1234, 16'h1234, 16'h4321, 16'h5555, 16'h6666, 16'h4321};
    slow <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      cfg(32'(c[i]));
      n = i_fb_mem_model.wr_cnt;
      wr(32'h0000_2000 + 32'(4 * (5 + i)), d[i]);
      chk("pixels", 32'(i_fb_mem_model.wr_cnt - n), 32'h0000_0001);
      px(5 + i, 2, (i == 1) ? 16'h001F : 16'hF800, 0);
      px(5 + i, 2, ed[i], 1);
    end
    slow <= 1'b0;
    $display("p32 done");
  endtask : t_p32

  task automatic t_geom();
    int n;
    cfg(32'h0000_0005);
    axi_wr(`REG_RENDER_MODE_CONFIG, 32'h0001_0000, `AXI_RESP_OKAY);
    wr(32'h0000_0020, 32'h00FF_0000);
    wr(32'h0000_0024, 32'h0000_00FF);
    px(8, SCR_H - 1, 16'hF800, 0);
    px(9, SCR_H - 1, 16'h001F, 0);
    axi_wr(`REG_RENDER_MODE_CONFIG, 32'h0000_0001, `AXI_RESP_OKAY);
    n = i_fb_mem_model.wr_cnt;
    wr(32'h0000_1A00, 32'h0000_FF00);
    wr(32'h001E_0000, 32'h0000_FF00);
    chk("clipped", 32'(i_fb_mem_model.wr_cnt - n), 32'h0000_0000);
    wr(32'hFFFF_FFFC, 32'h0000_FF00);
    wr(32'h0040_0000, 32'h0000_FF00);
    chk("outside", 32'(i_fb_mem_model.wr_cnt - n), 32'h0000_0000);
    wr(32'h0000_19FC, 32'h0000_FF00);
    px(639, 1, 16'h07E0, 0);
    axi_wr(`REG_RENDER_MODE_CONFIG, 32'h0000_0000, `AXI_RESP_OKAY);
    $display("geom done");
  endtask : t_geom

  task automatic t_rsvd();
    int n;
    logic [3:0] f [7] = '{4'h3, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB};
    n = i_fb_mem_model.wr_cnt;
    foreach (f[i]) begin
      cfg(32'(f[i]));
      wr(32'h0000_0100, 32'hFFFF_FFFF);
    end
    chk("dropped", 32'(i_fb_mem_model.wr_cnt - n), 32'h0000_0000);
    rchk(`REG_STATUS, 32'h0000_0007, `AXI_RESP_OKAY);
    $display("rsvd done");
  endtask : t_rsvd

  task automatic t_read();
    int n;
    logic [31:0] q;
    cfg(32'h0000_0005);
    n = i_fb_mem_model.rd_cnt;
    @(posedge clk_sys);
    cmd_fifo_empty <= 1'b0;
    pixel_pipe_idle <= 1'b0;
    fork
      hst(1'b0, 32'h0000_1814, 32'h0000_0000, q);
      begin
        repeat (20) @(posedge clk_sys);
        chk("early", 32'(i_fb_mem_model.rd_cnt - n), 32'h0000_0000);
        cmd_fifo_empty <= 1'b1;
        repeat (10) @(posedge clk_sys);
        chk("early", 32'(i_fb_mem_model.rd_cnt - n), 32'h0000_0000);
        pixel_pipe_idle <= 1'b1;
      end
    join
    chk("rword", q, 32'hF800_001F);
    slow <= 1'b1;
    cfg(32'h0000_0805);
    rchk(`REG_STATUS, 32'h0000_0007, `AXI_RESP_OKAY);
    hst(1'b0, 32'h0000_1814, 32'h0000_0000, q);
    chk("rword", q, 32'h001F_F800);
    slow <= 1'b0;
    $display("test read done");
  endtask : t_read

  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_p16();
    t_p32();
    t_geom();
    t_rsvd();
    t_read();
    report_and_stop();
  end
endmodule : tb_top
